// [design/rx_map.svh]
`ifndef RX_MAP_SVH
`define RX_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RX_ADDR_CTRL 12'h000
`define RX_ADDR_STAT 12'h004
`define RX_ADDR_DATA 12'h008
`define RX_ADDR_DIV 12'h00C

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define RX_CTRL_EN 0
`define RX_CTRL_MODE_LO 1
`define RX_CTRL_MODE_HI 2
`define RX_CTRL_PAR_EN 3
`define RX_CTRL_PAR_ODD 4
`define RX_CTRL_STOP2 5
`define RX_CTRL_IE_RXC 6
`define RX_CTRL_IE_ERR 7

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define RX_STAT_RXC 0
`define RX_STAT_ERR 1
`define RX_STAT_PER 2
`define RX_STAT_OER 3
`define RX_STAT_FER 4
`define RX_STAT_ACK 5

// ----------------------------------------------------------------
// reset values and sampling counts
// ----------------------------------------------------------------
`define RX_DIV_RESET 24'h00001A
`define RX_OVS_MID 4'h7
`define RX_OVS_LAST 4'hF
`define RX_BIT_LAST8 3'h7
`define RX_BIT_LAST7 3'h6

`endif

// [design/rx_pkg.sv]
package rx_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_start,
    st_data,
    st_parity,
    st_stop1,
    st_stop2
  } frame_state_t;

endpackage

// [design/sample_if.sv]
`timescale 1ns/1ns
interface sample_if #(parameter int DIV_W = 24);
  logic run;
  logic [DIV_W-1:0] divisor;
  logic tick;
  logic level;

  modport gen (input run, input divisor, output tick, output level);
  modport user (output run, output divisor, input tick, input level);
endinterface

// [design/sample_gen.sv]
`timescale 1ns/1ns
module sample_gen #(
  parameter int DIV_W = 24
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // line
  input wire logic serial_in_pin,
  // towards the frame engine
  sample_if.gen smp
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [DIV_W-1:0] cnt;
    logic tick;
  } gen_state_t;

  gen_state_t s;
  gen_state_t next_s;

  // ----------------------------------------------------------------
  // oversampling tick, one every divisor+1 cycles
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sync1 = serial_in_pin;
    next_s.sync2 = s.sync1;
    next_s.tick = 1'b0;
    if (!smp.run) begin
      next_s.cnt = '0;
    end else if (s.cnt == '0) begin
      next_s.cnt = smp.divisor;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  // idle line is high, so the synchroniser resets high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{sync1: 1'b1, sync2: 1'b1, cnt: '0, tick: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign smp.tick = s.tick;
  assign smp.level = s.sync2;

endmodule

// [design/async_serial_receiver.sv]
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "rx_map.svh"
// How it works
// - writing enable 0 disables receiver and clears parity, overrun, framing flags
// - writing enable 1 enables receiver and starts watching for start bit
// - low start bit starts sampling; each data bit shifted in at mid-bit
// - low stop bit gives framing error and sets shared error flag
// - frame end copies shift register to buffer and sets complete flag
// - complete interrupt is complete flag gated by its enable
// - overrun frame sets neither complete flag nor complete interrupt
// - parity checked when word moves into the buffer
// - data plus parity bit count even or odd per odd select
// - parity error sets parity flag and shared error flag
// - parity flag clears on software write of 1 or on writing enable 0
// - framing error sets framing and shared flags; write 1 clears
// - word is buffered and reception continues despite errors
// - frame before acknowledge sets overrun and shared flag; write 1 clears
// - acknowledge in the same cycle as a transfer counts as overrun
// - error interrupt is shared error flag gated by its enable
// - mode bits 0/1 give 7-bit, 1/1 give 8-bit data
// - one start bit; one or two stop bits by stop select
// - complete flag also set on parity or framing error
// - shared error flag clears only on software write of 1
module async_serial_receiver #(
  parameter int DIV_W = 24
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line
  input wire logic serial_in_pin,
  // interrupt requests
  output logic rx_complete_irq,
  output logic error_irq
);

  if (DIV_W < 8 || DIV_W > 24) begin : g_check
    $error("DIV_W must lie between 8 and 24");
  end

  typedef struct packed {
    logic rx_enable_bit;
    logic mode_select_low;
    logic mode_select_high;
    logic parity_enable_bit;
    logic parity_odd_select;
    logic stop_len_select;
    logic ie_rxc;
    logic ie_err;
    logic [DIV_W-1:0] div;
    logic rx_complete_irq_flag;
    logic error_irq_flag;
    logic parity_err_flag;
    logic overrun_err_flag;
    logic framing_err_flag;
    logic unread;
    logic [7:0] rx_buffer;
    logic [31:0] rdata;
    logic slverr;
    rx_pkg::frame_state_t fs;
    logic [3:0] ovs;
    logic [2:0] bidx;
    logic [7:0] sh;
    logic par;
    logic ferr;
    logic prev;
  } rx_state_t;

  rx_state_t s;
  rx_state_t next_s;

  sample_if #(.DIV_W(DIV_W)) smp ();

  sample_gen #(.DIV_W(DIV_W)) u_gen (
    .pclk(pclk),
    .presetn(presetn),
    .serial_in_pin(serial_in_pin),
    .smp(smp)
  );

  logic ctrl_wr;
  logic stat_wr;
  logic ack;
  logic done;
  logic ovr;
  logic per_now;
  logic fe_now;
  logic run;
  logic [2:0] last_bit;

  assign run = s.rx_enable_bit & s.mode_select_high;
  assign smp.run = run;
  assign smp.divisor = s.div;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    ctrl_wr = psel & penable & pwrite & (paddr == `RX_ADDR_CTRL);
    stat_wr = psel & penable & pwrite & (paddr == `RX_ADDR_STAT);
    ack = stat_wr & pwdata[`RX_STAT_ACK];
    done = 1'b0;
    fe_now = 1'b0;
    per_now = 1'b0;
    ovr = 1'b0;
    // low mode bit picks the word length
    last_bit = s.mode_select_low ? `RX_BIT_LAST8 : `RX_BIT_LAST7;
    next_s.prev = smp.level;

    // read data is latched in the setup phase, served in access
    if (psel && !penable) begin
      next_s.slverr = 1'b0;
      next_s.rdata = 32'h00000000;
      unique case (paddr)
        `RX_ADDR_CTRL: begin
          next_s.rdata[`RX_CTRL_EN] = s.rx_enable_bit;
          next_s.rdata[`RX_CTRL_MODE_LO] = s.mode_select_low;
          next_s.rdata[`RX_CTRL_MODE_HI] = s.mode_select_high;
          next_s.rdata[`RX_CTRL_PAR_EN] = s.parity_enable_bit;
          next_s.rdata[`RX_CTRL_PAR_ODD] = s.parity_odd_select;
          next_s.rdata[`RX_CTRL_STOP2] = s.stop_len_select;
          next_s.rdata[`RX_CTRL_IE_RXC] = s.ie_rxc;
          next_s.rdata[`RX_CTRL_IE_ERR] = s.ie_err;
        end
        `RX_ADDR_STAT: begin
          next_s.rdata[`RX_STAT_RXC] = s.rx_complete_irq_flag;
          next_s.rdata[`RX_STAT_ERR] = s.error_irq_flag;
          next_s.rdata[`RX_STAT_PER] = s.parity_err_flag;
          next_s.rdata[`RX_STAT_OER] = s.overrun_err_flag;
          next_s.rdata[`RX_STAT_FER] = s.framing_err_flag;
          next_s.rdata[`RX_STAT_ACK] = s.fs != rx_pkg::st_idle;
        end
        `RX_ADDR_DATA: next_s.rdata[7:0] = s.rx_buffer;
        `RX_ADDR_DIV: next_s.rdata[DIV_W-1:0] = s.div;
        default: next_s.slverr = 1'b1;
      endcase
    end

    // ----------------------------------------------------------------
    // frame engine, leaves idle on any clock's start edge, then steps on oversampling ticks
    // ----------------------------------------------------------------
    if (run) begin
      unique case (s.fs)
        rx_pkg::st_idle: begin
          // only a falling edge of an idle-high line starts
          if (s.prev && !smp.level) begin
            next_s.fs = rx_pkg::st_start;
            next_s.ovs = 4'h0;
          end
        end
        rx_pkg::st_start: begin
          if (smp.tick) begin
            next_s.ovs = s.ovs + 4'h1;
            // a start still low at mid-bit opens the frame
            if (s.ovs == `RX_OVS_MID) begin
              next_s.ovs = 4'h0;
              next_s.bidx = 3'h0;
              next_s.sh = 8'h00;
              next_s.par = 1'b0;
              next_s.ferr = 1'b0;
              next_s.fs = smp.level ? rx_pkg::st_idle : rx_pkg::st_data;
            end
          end
        end
        rx_pkg::st_data: begin
          if (smp.tick) begin
            next_s.ovs = s.ovs + 4'h1;
            if (s.ovs == `RX_OVS_LAST) begin
              // one data bit per bit period, lsb first
              // bit 7 stays cleared in 7-bit mode
              next_s.sh[s.bidx] = smp.level;
              next_s.par = s.par ^ smp.level;
              next_s.bidx = s.bidx + 3'h1;
              if (s.bidx == last_bit) begin
                next_s.fs = s.parity_enable_bit ? rx_pkg::st_parity
                                                : rx_pkg::st_stop1;
              end
            end
          end
        end
        rx_pkg::st_parity: begin
          if (smp.tick) begin
            next_s.ovs = s.ovs + 4'h1;
            if (s.ovs == `RX_OVS_LAST) begin
              next_s.par = s.par ^ smp.level;
              next_s.fs = rx_pkg::st_stop1;
            end
          end
        end
        rx_pkg::st_stop1, rx_pkg::st_stop2: begin
          if (smp.tick) begin
            next_s.ovs = s.ovs + 4'h1;
            if (s.ovs == `RX_OVS_LAST) begin
              // a low stop bit is a framing error
              next_s.ferr = s.ferr | ~smp.level;
              // second stop bit only when selected
              if (s.fs == rx_pkg::st_stop1 && s.stop_len_select) begin
                next_s.fs = rx_pkg::st_stop2;
              end else begin
                next_s.fs = rx_pkg::st_idle;
                done = 1'b1;
                fe_now = s.ferr | ~smp.level;
              end
            end
          end
        end
      endcase
    end

    // ----------------------------------------------------------------
    // software writes; clears first so that events below win
    // ----------------------------------------------------------------
    if (ctrl_wr) begin
      next_s.rx_enable_bit = pwdata[`RX_CTRL_EN];
      next_s.mode_select_low = pwdata[`RX_CTRL_MODE_LO];
      next_s.mode_select_high = pwdata[`RX_CTRL_MODE_HI];
      next_s.parity_enable_bit = pwdata[`RX_CTRL_PAR_EN];
      next_s.parity_odd_select = pwdata[`RX_CTRL_PAR_ODD];
      next_s.stop_len_select = pwdata[`RX_CTRL_STOP2];
      next_s.ie_rxc = pwdata[`RX_CTRL_IE_RXC];
      next_s.ie_err = pwdata[`RX_CTRL_IE_ERR];
    end
    if (psel && penable && pwrite && paddr == `RX_ADDR_DIV) begin
      next_s.div = pwdata[DIV_W-1:0];
    end
    if (stat_wr) begin
      if (pwdata[`RX_STAT_RXC]) next_s.rx_complete_irq_flag = 1'b0;
      // shared error flag cleared by writing 1
      if (pwdata[`RX_STAT_ERR]) next_s.error_irq_flag = 1'b0;
      // parity flag cleared by writing 1
      if (pwdata[`RX_STAT_PER]) next_s.parity_err_flag = 1'b0;
      // overrun flag cleared by writing 1
      if (pwdata[`RX_STAT_OER]) next_s.overrun_err_flag = 1'b0;
      // framing flag cleared by writing 1
      if (pwdata[`RX_STAT_FER]) next_s.framing_err_flag = 1'b0;
      if (ack) next_s.unread = 1'b0;
    end

    // ----------------------------------------------------------------
    // transfer to the receive buffer
    // ----------------------------------------------------------------
    if (done) begin
      // parity judged at the moment of transfer
      // total ones must match the odd select
      per_now = s.parity_enable_bit & (next_s.par != s.parity_odd_select);
      // an acknowledge in this same cycle is still an overrun
      ovr = s.unread | ack;
      next_s.rx_buffer = next_s.sh;
      next_s.unread = 1'b1;
      // parity and framing errors still complete
      if (!ovr) next_s.rx_complete_irq_flag = 1'b1;
      // parity error sets its flag and the shared one
      if (per_now) next_s.parity_err_flag = 1'b1;
      // framing error sets its flag and the shared one
      if (fe_now) next_s.framing_err_flag = 1'b1;
      // frame before acknowledge is an overrun
      if (ovr) next_s.overrun_err_flag = 1'b1;
      if (per_now || fe_now || ovr) next_s.error_irq_flag = 1'b1;
    end

    // disable is a reset of the engine and the parity, overrun and framing flags
    if (ctrl_wr && !pwdata[`RX_CTRL_EN]) begin
      next_s.fs = rx_pkg::st_idle;
      next_s.parity_err_flag = 1'b0;
      next_s.overrun_err_flag = 1'b0;
      next_s.framing_err_flag = 1'b0;
      next_s.unread = 1'b0;
    end
    // enable arms the start watch from a clean idle
    if (ctrl_wr && pwdata[`RX_CTRL_EN] && !s.rx_enable_bit) begin
      next_s.fs = rx_pkg::st_idle;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.div <= DIV_W'(`RX_DIV_RESET);
      s.prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = s.rdata;
  assign pready = 1'b1;
  assign pslverr = s.slverr & psel & penable;
  assign rx_complete_irq = s.rx_complete_irq_flag & s.ie_rxc;
  assign error_irq = s.error_irq_flag & s.ie_err;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_disable_clears: assert property (
    ctrl_wr && !pwdata[`RX_CTRL_EN] |=> !s.parity_err_flag &&
      !s.overrun_err_flag && !s.framing_err_flag &&
      s.fs == rx_pkg::st_idle)
    else $error("disable left error flags or engine active");

  a_enable_arms: assert property (
    ctrl_wr && pwdata[`RX_CTRL_EN] |=> s.rx_enable_bit)
    else $error("enable write not taken");

  a_start_edge: assert property (
    run && s.fs == rx_pkg::st_idle && s.prev && !smp.level && !ctrl_wr
      |=> s.fs == rx_pkg::st_start)
    else $error("falling edge did not start a frame");

  a_buffer_load: assert property (
    done && !(ctrl_wr && !pwdata[`RX_CTRL_EN])
      |=> s.rx_buffer == $past(next_s.sh) && s.unread)
    else $error("buffer not loaded at frame end");

  a_seven_bit_top: assert property (
    done && !s.mode_select_low |=> !s.rx_buffer[7])
    else $error("7-bit word has top bit set");

  a_frame_error: assert property (
    done && fe_now && !ctrl_wr |=> s.framing_err_flag && s.error_irq_flag)
    else $error("framing error not flagged");

  a_parity_error: assert property (
    done && per_now && !ctrl_wr |=> s.parity_err_flag && s.error_irq_flag)
    else $error("parity error not flagged");

  a_overrun_quiet: assert property (
    done && ovr && !s.rx_complete_irq_flag
      |=> !s.rx_complete_irq_flag && !rx_complete_irq)
    else $error("overrun raised completion");

  a_overrun_ack: assert property (
    done && ack && !ctrl_wr |=> s.overrun_err_flag && s.unread)
    else $error("coinciding acknowledge not an overrun");

  a_complete_irq: assert property (
    done && !ovr && s.ie_rxc && !ctrl_wr |=> rx_complete_irq)
    else $error("completion interrupt missing");

  a_error_irq: assert property (
    done && (per_now || fe_now || ovr) && s.ie_err && !ctrl_wr
      |=> error_irq)
    else $error("error interrupt missing");

  c_clean_frame: cover property (done && !per_now && !fe_now && !ovr);
  c_parity_frame: cover property (done && per_now);
  c_overrun_frame: cover property (done && ovr);
  c_framing_frame: cover property (done && fe_now);

endmodule

// [dv/rx_line_model.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------
// remote transmitter on the serial line
// ----------------------------------------------------------------
module rx_line_model #(
  parameter int BIT_CYC = 32
) (
  // clock
  input wire logic pclk,
  // serial line
  output logic line
);
  initial line = 1'b1;

  task automatic hold(input logic v);
    line <= v;
    repeat (BIT_CYC) @(posedge pclk);
  endtask

  // a frame starts one edge after the call, so the line is high beforehand
  task automatic send(input logic [7:0] d, input int nbits,
      input logic par_en, input logic par_odd, input logic bad_par,
      input int nstop, input logic bad_stop);
    logic p;
    p = par_odd ^ bad_par;
    @(posedge pclk);
    hold(1'b0);
    for (int i = 0; i < nbits; i++) begin
      p = p ^ d[i];
      hold(d[i]);
    end
    if (par_en)
      hold(p);
    for (int i = 1; i <= nstop; i++)
      hold(!(bad_stop && i == nstop));
    line <= 1'b1;
  endtask
endmodule

// [dv/async_serial_receiver_tb_top.sv]
`timescale 1ns/1ns
`include "rx_map.svh"
module async_serial_receiver_tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int DIV = 1;
  localparam int BIT_CYC = 16 * (DIV + 1);
  // enable, 8-bit async mode, both interrupt enables
  localparam logic [31:0] B8 = 32'h000000C7;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic serial_in_pin, rx_complete_irq, error_irq;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #10 pclk = ~pclk;

  async_serial_receiver #(.DIV_W(24)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
    .rx_complete_irq(rx_complete_irq), .error_irq(error_irq));

  rx_line_model #(.BIT_CYC(BIT_CYC)) partner (
    .pclk(pclk), .line(serial_in_pin));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task end_of_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp,
      input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed; the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    check_bit(pready, 1'b1, "apb answer");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check_word(rd, exp, "register read");
  endtask

  // let the last frame's flag updates settle before looking at pins
  task automatic rx(input logic [7:0] d, input int nbits, input logic pe,
      input logic po, input logic bp, input int ns, input logic bs);
    partner.send(d, nbits, pe, po, bp, ns, bs);
    @(negedge pclk);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      $display("BAD %0t watchdog expired", $time);
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`RX_ADDR_CTRL, 32'h00000000);
    rdchk(`RX_ADDR_STAT, 32'h00000000);
    rdchk(`RX_ADDR_DATA, 32'h00000000);
    rdchk(`RX_ADDR_DIV, 32'h0000001A);
    apb(1'b0, 12'h010, 32'h00000000);
    check_bit(err, 1'b1, "unmapped error");
    check_word(rd, 32'h00000000, "unmapped data");
    wr(`RX_ADDR_DIV, 32'(DIV));
    wr(`RX_ADDR_CTRL, B8);
    rdchk(`RX_ADDR_CTRL, B8);
    rx(8'hA5, 8, 1'b0, 1'b0, 1'b0, 1, 1'b0);
    check_bit(rx_complete_irq, 1'b1, "complete irq");
    check_bit(error_irq, 1'b0, "clean frame error irq");
    rdchk(`RX_ADDR_DATA, 32'h000000A5);
    rdchk(`RX_ADDR_STAT, 32'h00000001);
    wr(`RX_ADDR_DATA, 32'h000000FF);
    rdchk(`RX_ADDR_DATA, 32'h000000A5);
    wr(`RX_ADDR_CTRL, B8 & 32'hFFFFFFBF);
    @(negedge pclk);
    check_bit(rx_complete_irq, 1'b0, "masked complete irq");
    wr(`RX_ADDR_CTRL, B8);
    wr(`RX_ADDR_STAT, 32'h00000021);
    rdchk(`RX_ADDR_STAT, 32'h00000000);
    for (int po = 0; po < 2; po++) begin
      for (int bp = 0; bp < 2; bp++) begin
        wr(`RX_ADDR_CTRL, B8 | 32'h00000008 | (32'(po) << 4));
        rx(8'h3C, 8, 1'b1, po[0], bp[0], 1, 1'b0);
        check_bit(error_irq, bp[0], "parity error irq");
        rdchk(`RX_ADDR_DATA, 32'h0000003C);
        rdchk(`RX_ADDR_STAT, bp ? 32'h00000007 : 32'h00000001);
        wr(`RX_ADDR_STAT, 32'h00000020);
        rdchk(`RX_ADDR_STAT, bp ? 32'h00000007 : 32'h00000001);
        wr(`RX_ADDR_STAT, 32'h0000003F);
        rdchk(`RX_ADDR_STAT, 32'h00000000);
      end
    end
    wr(`RX_ADDR_CTRL, 32'h000000E5);
    rx(8'hFF, 7, 1'b0, 1'b0, 1'b0, 2, 1'b0);
    rdchk(`RX_ADDR_DATA, 32'h0000007F);
    rdchk(`RX_ADDR_STAT, 32'h00000001);
    wr(`RX_ADDR_STAT, 32'h0000003F);
    rx(8'h55, 7, 1'b0, 1'b0, 1'b0, 2, 1'b1);
    check_bit(error_irq, 1'b1, "framing error irq");
    rdchk(`RX_ADDR_DATA, 32'h00000055);
    rdchk(`RX_ADDR_STAT, 32'h00000013);
    wr(`RX_ADDR_STAT, 32'h00000010);
    rdchk(`RX_ADDR_STAT, 32'h00000003);
    wr(`RX_ADDR_STAT, 32'h0000003F);
    wr(`RX_ADDR_CTRL, B8);
    rx(8'h11, 8, 1'b0, 1'b0, 1'b0, 1, 1'b0);
    rdchk(`RX_ADDR_STAT, 32'h00000001);
    wr(`RX_ADDR_STAT, 32'h00000001);
    rx(8'h22, 8, 1'b0, 1'b0, 1'b0, 1, 1'b0);
    check_bit(rx_complete_irq, 1'b0, "overrun complete irq");
    check_bit(error_irq, 1'b1, "overrun error irq");
    rdchk(`RX_ADDR_DATA, 32'h00000022);
    rdchk(`RX_ADDR_STAT, 32'h0000000A);
    wr(`RX_ADDR_CTRL, 32'h00000000);
    apb(1'b0, `RX_ADDR_STAT, 32'h00000000);
    check_word(rd & 32'h0000001C, 32'h00000000, "disable clear");
    rx(8'h66, 8, 1'b0, 1'b0, 1'b0, 1, 1'b0);
    rdchk(`RX_ADDR_DATA, 32'h00000022);
    apb(1'b0, `RX_ADDR_STAT, 32'h00000000);
    check_word(rd & 32'h00000001, 32'h00000000, "disabled frame");
    wr(`RX_ADDR_STAT, 32'h0000003F);
    wr(`RX_ADDR_CTRL, B8);
    rx(8'h99, 8, 1'b0, 1'b0, 1'b0, 1, 1'b0);
    rdchk(`RX_ADDR_DATA, 32'h00000099);
    rdchk(`RX_ADDR_STAT, 32'h00000001);
    wr(`RX_ADDR_STAT, 32'h00000021);
    wr(`RX_ADDR_CTRL, 32'h00000000);
    // enable from disabled fixes the tick phase; the stop sample falls
    // on tick 154, 308 cycles on, where the ack access is placed
    wr(`RX_ADDR_CTRL, B8);
    fork
      partner.send(8'h4E, 8, 1'b0, 1'b0, 1'b0, 1, 1'b0);
      begin
        repeat (305) @(posedge pclk);
        wr(`RX_ADDR_STAT, 32'h00000020);
      end
    join
    @(negedge pclk);
    check_bit(rx_complete_irq, 1'b0, "coinciding ack complete irq");
    check_bit(error_irq, 1'b1, "coinciding ack error irq");
    rdchk(`RX_ADDR_DATA, 32'h0000004E);
    rdchk(`RX_ADDR_STAT, 32'h0000000A);
    wr(`RX_ADDR_STAT, 32'h0000003F);
    wr(`RX_ADDR_CTRL, 32'h00000000);
    end_of_test();
  end
endmodule
